// ### rtl/acq_cfg.svh
// offsets, field positions, reset values and timing counts for the queued converter front end
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH
// ------------------------------------------------------------
// host register indices
// ------------------------------------------------------------
`define ACQ_A_PUSH 2'h0
`define ACQ_A_QCTRL 2'h1
`define ACQ_A_STATUS 2'h2
`define ACQ_A_POP 2'h3
// ------------------------------------------------------------
// queue control and status fields
// ------------------------------------------------------------
`define ACQ_MODE_HI 7
`define ACQ_MODE_LO 4
`define ACQ_MODE_SINGLE_SW 4'h1
`define ACQ_SSE_BIT 10
`define ACQ_ST_DRAIN 0
`define ACQ_ST_EOQ 1
`define ACQ_ST_REFUSED 2
`define ACQ_ST_ACTIVE 3
// ------------------------------------------------------------
// command word fields
// ------------------------------------------------------------
`define ACQ_CW_EOQ 31
`define ACQ_CW_BN 25
`define ACQ_CW_RW 24
`define ACQ_CW_VAL_HI 23
`define ACQ_CW_VAL_LO 8
`define ACQ_CW_ADDR_HI 7
`define ACQ_CW_ADDR_LO 0
`define ACQ_CW_TAG_HI 23
`define ACQ_CW_TAG_LO 20
`define ACQ_CW_FMT 16
`define ACQ_CW_CH_HI 15
`define ACQ_CW_CH_LO 8
`define ACQ_CONV_ADDR 8'h00
// ------------------------------------------------------------
// converter internal register and timing
// ------------------------------------------------------------
`define ACQ_CREG_ADDR 8'h01
`define ACQ_CREG_RESET 16'h0000
`define ACQ_CREG_EN 15
`define ACQ_CREG_ODD 5
`define ACQ_CREG_PS_HI 4
`define ACQ_CREG_PS_LO 0
`define ACQ_CONV_TICKS 4'hE
`define ACQ_DEPTH 4
`endif

// ### rtl/acq_pkg.sv
// types shared by the queued converter front end
package acq_pkg;
  typedef enum logic [2:0] {
    ACQ_IDLE,
    ACQ_FETCH,
    ACQ_EXEC,
    ACQ_CONV,
    ACQ_RESULT,
    ACQ_DONE
  } acq_state_e;
endpackage

// ### rtl/acq_fifo.sv
// small in-order queue memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module acq_fifo #(
  parameter int W = 32,
  parameter int D = 4,
  parameter int AW = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] pop_data,
  output logic full,
  output logic empty,
  output logic [AW:0] count
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic do_push;
  logic do_pop;

  // a push into a full queue or a pop from an empty one is ignored
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  // depth needs the extra count bit, a narrower cast would wrap it to zero
  assign full = (count == (AW+1)'(D));
  assign empty = (count == '0);

  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wptr_reg] <= push_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // oldest word leaves through a register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pop_data <= '0;
    end else if (do_pop) begin
      pop_data <= mem[rptr_reg];
    end
  end
endmodule
`default_nettype wire

// ### rtl/acq_top.sv
// queued converter front end: command queue, converter 0 control, result queue
// Behaviour
// - converter clock is system clock over ratio
// - control register holds enable and prescale field
// - configuration word: eoq, buffer, rw, value, address
// - converter control register answers at address 1
// - queue control 0x0410 starts single software scan
// - end-of-queue command sets end of queue flag
// - status flags clear on written one only
// - conversion word: channel, tag, buffer, format, eoq
// - result entering queue sets drain flag
// - pop read returns and removes oldest result
`timescale 1ns/1ps
`default_nettype none
`include "acq_cfg.svh"
module acq_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  output logic converter_zero_enable,
  output logic conv_clk_tick,
  output logic conv_start,
  output logic [7:0] conv_channel,
  input wire logic [11:0] conv_data
);
  acq_pkg::acq_state_e state_reg;
  logic [15:0] ctrl_reg;
  logic [3:0] mode_reg;
  logic scan_active_reg;
  logic drain_flag_reg;
  logic eoq_flag_reg;
  logic refused_flag_reg;
  logic [6:0] div_cnt_reg;
  logic [6:0] ratio;
  logic [3:0] conv_cnt_reg;
  logic [15:0] res_val_reg;
  logic rd_q_reg;
  logic [1:0] rd_addr_q_reg;
  logic pop_hit_q_reg;
  logic cmd_push, cmd_pop, cmd_full, cmd_empty;
  logic [31:0] cmd_word;
  logic [2:0] cmd_count;
  logic res_push, res_pop, res_full, res_empty;
  logic [15:0] res_word;
  logic [2:0] res_count;
  logic ctrl_wr, start_req, is_conv, finish, status_wr;

  // ------------------------------------------------------------
  // queues
  // ------------------------------------------------------------
  acq_fifo #(.W(32), .D(`ACQ_DEPTH), .AW(2)) cmd_q (
    .core_clk(core_clk), .resetn(resetn), .push(cmd_push), .push_data(host_wdata),
    .pop(cmd_pop), .pop_data(cmd_word), .full(cmd_full), .empty(cmd_empty), .count(cmd_count)
  );
  acq_fifo #(.W(16), .D(`ACQ_DEPTH), .AW(2)) res_q (
    .core_clk(core_clk), .resetn(resetn), .push(res_push), .push_data(res_val_reg),
    .pop(res_pop), .pop_data(res_word), .full(res_full), .empty(res_empty), .count(res_count)
  );

  // ------------------------------------------------------------
  // host decode
  // ------------------------------------------------------------
  assign cmd_push = host_wr && (host_addr == `ACQ_A_PUSH);
  assign status_wr = host_wr && (host_addr == `ACQ_A_STATUS);
  assign res_pop = host_rd && (host_addr == `ACQ_A_POP);
  assign start_req = host_wr && (host_addr == `ACQ_A_QCTRL) && host_wdata[`ACQ_SSE_BIT]
    && (host_wdata[`ACQ_MODE_HI:`ACQ_MODE_LO] == `ACQ_MODE_SINGLE_SW);
  // one word at a time, head first
  assign cmd_pop = (state_reg == acq_pkg::ACQ_FETCH);
  assign is_conv = (cmd_word[`ACQ_CW_ADDR_HI:`ACQ_CW_ADDR_LO] == `ACQ_CONV_ADDR);
  // only buffer 0 write to address 1 reaches the control register
  assign ctrl_wr = (state_reg == acq_pkg::ACQ_EXEC) && !is_conv && !cmd_word[`ACQ_CW_BN]
    && !cmd_word[`ACQ_CW_RW] && (cmd_word[`ACQ_CW_ADDR_HI:`ACQ_CW_ADDR_LO] == `ACQ_CREG_ADDR);
  assign res_push = (state_reg == acq_pkg::ACQ_RESULT) && !res_full;
  assign finish = (state_reg == acq_pkg::ACQ_DONE);
  assign ratio = {1'b0, ctrl_reg[`ACQ_CREG_PS_HI:`ACQ_CREG_PS_LO], 1'b0} + 7'h02
    + {6'h00, ctrl_reg[`ACQ_CREG_ODD]};

  // mode field and scan activity
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= 4'h0;
      scan_active_reg <= 1'b0;
    end else begin
      if (host_wr && (host_addr == `ACQ_A_QCTRL)) begin
        mode_reg <= host_wdata[`ACQ_MODE_HI:`ACQ_MODE_LO];
      end
      if (finish && cmd_word[`ACQ_CW_EOQ]) begin
        scan_active_reg <= 1'b0;
      end else if (start_req) begin
        scan_active_reg <= 1'b1;
      end
    end
  end

  // status flags: hardware set wins over a written one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drain_flag_reg <= 1'b0;
      eoq_flag_reg <= 1'b0;
      refused_flag_reg <= 1'b0;
    end else begin
      drain_flag_reg <= (drain_flag_reg && !(status_wr && host_wdata[`ACQ_ST_DRAIN])) || res_push;
      eoq_flag_reg <= (eoq_flag_reg && !(status_wr && host_wdata[`ACQ_ST_EOQ]))
        || (finish && cmd_word[`ACQ_CW_EOQ]);
      refused_flag_reg <= (refused_flag_reg && !(status_wr && host_wdata[`ACQ_ST_REFUSED]))
        || (cmd_push && cmd_full);
    end
  end

  // ------------------------------------------------------------
  // converter 0 control and clock divider
  // ------------------------------------------------------------
  // enable and prescale held here
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `ACQ_CREG_RESET;
      converter_zero_enable <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= cmd_word[`ACQ_CW_VAL_HI:`ACQ_CW_VAL_LO];
      end
      converter_zero_enable <= ctrl_reg[`ACQ_CREG_EN];
    end
  end

  // one tick per ratio cycles, restarted on reprogram
  // divider free-runs so a disabled converter cannot hang the queue
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 7'h00;
      conv_clk_tick <= 1'b0;
    end else if (ctrl_wr) begin
      div_cnt_reg <= 7'h00;
      conv_clk_tick <= 1'b0;
    end else if (div_cnt_reg >= ratio - 7'h01) begin
      div_cnt_reg <= 7'h00;
      conv_clk_tick <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
      conv_clk_tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // command engine
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= acq_pkg::ACQ_IDLE;
      conv_cnt_reg <= 4'h0;
      res_val_reg <= 16'h0000;
      conv_start <= 1'b0;
      conv_channel <= 8'h00;
    end else begin
      conv_start <= 1'b0;
      case (state_reg)
        acq_pkg::ACQ_IDLE: begin
          if (scan_active_reg && !cmd_empty) begin
            state_reg <= acq_pkg::ACQ_FETCH;
          end
        end
        acq_pkg::ACQ_FETCH: begin
          state_reg <= acq_pkg::ACQ_EXEC;
        end
        acq_pkg::ACQ_EXEC: begin
          if (is_conv) begin
            conv_start <= !cmd_word[`ACQ_CW_BN];
            conv_channel <= cmd_word[`ACQ_CW_CH_HI:`ACQ_CW_CH_LO];
            conv_cnt_reg <= `ACQ_CONV_TICKS;
            state_reg <= acq_pkg::ACQ_CONV;
          end else if (cmd_word[`ACQ_CW_RW] && !cmd_word[`ACQ_CW_BN]) begin
            res_val_reg <= (cmd_word[`ACQ_CW_ADDR_HI:`ACQ_CW_ADDR_LO] == `ACQ_CREG_ADDR) ? ctrl_reg : 16'h0000;
            state_reg <= acq_pkg::ACQ_RESULT;
          end else begin
            state_reg <= acq_pkg::ACQ_DONE;
          end
        end
        acq_pkg::ACQ_CONV: begin
          if (conv_clk_tick) begin
            if (conv_cnt_reg == 4'h0) begin
              // unsigned, code shifted left two under two zero top bits; disabled converter yields zero
              res_val_reg <= converter_zero_enable ? {2'b00, conv_data, 2'b00} : 16'h0000;
              state_reg <= acq_pkg::ACQ_RESULT;
            end else begin
              conv_cnt_reg <= conv_cnt_reg - 4'h1;
            end
          end
        end
        acq_pkg::ACQ_RESULT: begin
          // full result queue stalls the engine, nothing dropped
          if (!res_full) begin
            state_reg <= acq_pkg::ACQ_DONE;
          end
        end
        acq_pkg::ACQ_DONE: begin
          state_reg <= acq_pkg::ACQ_IDLE;
        end
        default: begin
          state_reg <= acq_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // host read path, two cycles for every register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q_reg <= 1'b0;
      rd_addr_q_reg <= 2'h0;
      pop_hit_q_reg <= 1'b0;
      host_rdata <= 32'h00000000;
      host_rvalid <= 1'b0;
    end else begin
      rd_q_reg <= host_rd;
      rd_addr_q_reg <= host_addr;
      pop_hit_q_reg <= res_pop && !res_empty;
      host_rvalid <= rd_q_reg;
      if (rd_q_reg) begin
        case (rd_addr_q_reg)
          `ACQ_A_QCTRL: host_rdata <= {21'h000000, scan_active_reg, 2'b00, mode_reg, 4'h0};
          `ACQ_A_STATUS: host_rdata <= {17'h00000, res_count, 1'b0, cmd_count, 4'h0,
            scan_active_reg, refused_flag_reg, eoq_flag_reg, drain_flag_reg};
          `ACQ_A_POP: host_rdata <= pop_hit_q_reg ? {16'h0000, res_word} : 32'h00000000;
          default: host_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [6:0] gap_reg;
  logic gap_ok_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 7'h00;
      gap_ok_reg <= 1'b0;
    end else begin
      gap_reg <= conv_clk_tick ? 7'h01 : gap_reg + 7'h01;
      gap_ok_reg <= ctrl_wr ? 1'b0 : (gap_ok_reg || conv_clk_tick);
    end
  end
  div_gap_a: assert property (conv_clk_tick && gap_ok_reg && !ctrl_wr |-> gap_reg == ratio)
    else $error("converter tick spacing wrong");
  ctrl_load_a: assert property (ctrl_wr |=> ctrl_reg == $past(cmd_word[23:8]))
    else $error("control register not loaded");
  enable_out_a: assert property (ctrl_wr |=> ##1 converter_zero_enable == ctrl_reg[15])
    else $error("enable output wrong");
  scan_start_a: assert property (start_req && !finish |=> scan_active_reg)
    else $error("scan did not start");
  eoq_set_a: assert property (finish && cmd_word[31] |=> eoq_flag_reg && !scan_active_reg)
    else $error("end of queue flag missing");
  w1c_keep_a: assert property (status_wr && !host_wdata[0] && drain_flag_reg |=> drain_flag_reg)
    else $error("drain flag lost on zero write");
  w1c_clear_a: assert property (status_wr && host_wdata[1] && !finish |=> !eoq_flag_reg)
    else $error("end of queue flag not cleared");
  drain_set_a: assert property (res_push |=> drain_flag_reg && res_count != 3'h0)
    else $error("drain flag not set");
  pop_read_a: assert property (res_pop && !res_empty |-> ##2 host_rvalid && host_rdata[15:0] == $past(res_word))
    else $error("pop data wrong");
  fetch_order_a: assert property (cmd_pop |-> !cmd_empty ##1 state_reg == acq_pkg::ACQ_EXEC)
    else $error("fetch from empty queue");
  eoq_seen_c: cover property (finish && cmd_word[31]);
  conv_done_c: cover property (state_reg == acq_pkg::ACQ_CONV ##1 state_reg == acq_pkg::ACQ_RESULT);
  pop_hit_c: cover property (res_pop && !res_empty);
endmodule
`default_nettype wire

// ### sim/adc_command_queue_single_scan_bench.sv
// self-checking bench for the queued converter front end
`timescale 1ns/1ps
`default_nettype none
`include "acq_cfg.svh"
module adc_command_queue_single_scan_bench;
  logic core_clk, resetn, host_wr, host_rd, host_rvalid;
  logic [1:0] host_addr;
  logic [31:0] host_wdata, host_rdata, rd_val;
  logic converter_zero_enable, conv_clk_tick, conv_start, seen;
  logic [7:0] conv_channel;
  logic [11:0] conv_data;
  logic [7:0] chans[$];
  int bad_count, num_checks;

  acq_top dut_u (
    .core_clk(core_clk),
    .resetn(resetn),
    .host_addr(host_addr),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_wdata(host_wdata),
    .host_rdata(host_rdata),
    .host_rvalid(host_rvalid),
    .converter_zero_enable(converter_zero_enable),
    .conv_clk_tick(conv_clk_tick),
    .conv_start(conv_start),
    .conv_channel(conv_channel),
    .conv_data(conv_data)
  );

  // ------------------------------------------------------------
  // clock, converter stand-in and channel log
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // code follows the channel so each result shows which command made it
  always @(posedge core_clk) begin
    conv_data <= {4'h5, conv_channel};
  end

  // channel is logged one cycle after the start pulse, once it has landed
  always @(negedge core_clk) begin
    if (seen) chans.push_back(conv_channel);
    seen = (conv_start === 1'b1);
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask

  // rvalid is launched one edge after the taking edge and seen just after it
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (host_rvalid !== 1'b1 && n < 4);
    check(n, 1, "read latency");
    d = host_rdata;
  endtask

  // bounded polling, as host software would do
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    rd(`ACQ_A_STATUS, rd_val);
    // two queued conversions take about a thousand cycles, three per poll
    while (rd_val[b] !== 1'b1 && n < 1000) begin
      rd(`ACQ_A_STATUS, rd_val);
      n++;
    end
    check(rd_val[b], 1'b1, "status flag");
  endtask

  function automatic logic [31:0] exp_res(input logic [7:0] ch);
    return {16'h0000, 2'b00, 4'h5, ch, 2'b00};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val, 32'h0000_0000, "status after reset");
    rd(`ACQ_A_QCTRL, rd_val);
    check(rd_val, 32'h0000_0000, "queue control after reset");
    check(converter_zero_enable, 1'b0, "enable after reset");
  endtask

  task automatic t_config;
    int n;
    wr(`ACQ_A_PUSH, 32'h8080_0F01);
    wr(`ACQ_A_QCTRL, 32'h0000_0410);
    wait_flag(`ACQ_ST_EOQ);
    check(converter_zero_enable, 1'b1, "enable bit");
    for (n = 0; n < 40 && conv_clk_tick !== 1'b1; n++) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    for (n = 1; n < 40 && conv_clk_tick !== 1'b1; n++) @(posedge core_clk) #1;
    check(n, 32, "tick period");
    wr(`ACQ_A_STATUS, 32'h0000_0000);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[`ACQ_ST_EOQ], 1'b1, "flag kept on zero write");
    wr(`ACQ_A_STATUS, 32'h0000_0002);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[3:0], 4'h0, "flag cleared by one");
  endtask

  task automatic t_convert;
    wr(`ACQ_A_PUSH, 32'h8000_0500);
    wr(`ACQ_A_QCTRL, 32'h0000_0410);
    wait_flag(`ACQ_ST_DRAIN);
    rd(`ACQ_A_POP, rd_val);
    check(rd_val[15:0], exp_res(8'h05), "result");
    check(chans.pop_front(), 8'h05, "channel");
    wr(`ACQ_A_STATUS, 32'h0000_0003);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[2:0], 3'h0, "both flags cleared");
  endtask

  // a trigger without the single-scan mode must leave the queue alone
  task automatic t_order;
    wr(`ACQ_A_PUSH, 32'h0000_0300);
    wr(`ACQ_A_PUSH, 32'h8000_0700);
    wr(`ACQ_A_QCTRL, 32'h0000_0400);
    repeat (20) @(posedge core_clk);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[10:0], 11'h200, "queue held idle");
    check(chans.size(), 0, "no conversion started");
    wr(`ACQ_A_QCTRL, 32'h0000_0410);
    wait_flag(`ACQ_ST_EOQ);
    rd(`ACQ_A_POP, rd_val);
    check(rd_val[15:0], exp_res(8'h03), "first result");
    rd(`ACQ_A_POP, rd_val);
    check(rd_val[15:0], exp_res(8'h07), "second result");
    rd(`ACQ_A_POP, rd_val);
    check(rd_val, 32'h0000_0000, "empty pop");
    check(chans.pop_front(), 8'h03, "first channel");
    check(chans.pop_front(), 8'h07, "second channel");
  endtask

  // config reads, a buffer 1 no-op and a push into a full queue
  task automatic t_refuse;
    wr(`ACQ_A_STATUS, 32'h0000_0002);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[1:0], 2'h1, "drain kept, eoq cleared");
    wr(`ACQ_A_STATUS, 32'h0000_0001);
    wr(`ACQ_A_PUSH, 32'h0100_0001);
    wr(`ACQ_A_PUSH, 32'h0100_0002);
    wr(`ACQ_A_PUSH, 32'h0280_0001);
    wr(`ACQ_A_PUSH, 32'h8100_0001);
    wr(`ACQ_A_PUSH, 32'h0100_0001);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[10:0], 11'h404, "full queue refused push");
    wr(`ACQ_A_QCTRL, 32'h0000_0410);
    wait_flag(`ACQ_ST_EOQ);
    rd(`ACQ_A_POP, rd_val);
    check(rd_val, 32'h0000_800F, "control read back");
    rd(`ACQ_A_POP, rd_val);
    check(rd_val, 32'h0000_0000, "other address reads zero");
    rd(`ACQ_A_POP, rd_val);
    check(rd_val, 32'h0000_800F, "buffer 1 write ignored");
    rd(`ACQ_A_POP, rd_val);
    check(rd_val, 32'h0000_0000, "no fourth result");
    check(converter_zero_enable, 1'b1, "enable kept");
    wr(`ACQ_A_STATUS, 32'h0000_0007);
    rd(`ACQ_A_STATUS, rd_val);
    check(rd_val[3:0], 4'h0, "all flags cleared");
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic results;
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 2'h0;
    host_wdata = 32'h0000_0000;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset;
    t_config;
    t_convert;
    t_order;
    t_refuse;
    results;
  end

  // three conversions of 480 cycles plus polling fit well inside this
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
